// *** hdl/pmt_timer.sv ***
// Operation
// - count register is software read/write and cleared by every reset
// - count input is core clock over four, prescaled 1, 4 or 16
// - each match advances 4-bit postscaler; expiry sets timer match flag
// - writes to count or control, and reset, clear prescale and postscale counts
// - control write leaves the count value unchanged
// - count climbs to period, next increment returns to zero with a match
// - period register is software read/write, all ones after reset
// - match before postscaler goes out to the serial port
// - count value and period match go out to the PWM block
// - unimplemented register bits read as zero
module pmt_timer
    import pmt_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic [2:0]        i_awprot,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [3:0]        i_wstrb,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    output logic [1:0]             o_bresp,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    input  wire logic [2:0]        i_arprot,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    output logic [DATA_W-1:0]      o_rdata,
    output logic [1:0]             o_rresp,
    output logic                   o_serial_match,
    output pmt_pwm_feed_t          o_pwm_feed,
    output logic                   o_irq
);

    logic [ADDR_W-1:0] aw_addr_reg;
    logic [7:0]        w_data_reg;
    logic              w_lane_reg;
    logic              wr_fire;
    pmt_reg_sel_t      wr_sel;
    pmt_reg_sel_t      rd_sel;
    logic              wr_count;
    logic              wr_control;
    logic              wr_period;
    logic              wr_flags;
    logic              wr_enables;
    logic              wr_core_irq;
    logic [7:0]        rd_value;

    logic [7:0]        count_reg;
    logic [7:0]        period_reg;
    pmt_ctrl_t         ctrl_reg;
    logic [3:0]        post_cnt_reg;
    logic              match_flag_reg;
    logic              match_ie_reg;
    logic              periph_ie_reg;
    logic              global_ie_reg;
    logic              tick;
    logic              count_clear;
    logic              match_event;
    logic              post_expire;

    function automatic pmt_reg_sel_t decode(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-3:0] idx;
        idx = a[ADDR_W-1:2];
        if (a[1:0] != 2'h0)
            decode = SEL_NONE;
        else if (idx == {2'h0, IDX_CORE_IRQ_CTRL})
            decode = SEL_CORE_IRQ;
        else if (idx == {2'h0, IDX_PERIPH_FLAGS})
            decode = SEL_FLAGS;
        else if (idx == {2'h0, IDX_TIMER_COUNT})
            decode = SEL_COUNT;
        else if (idx == {2'h0, IDX_TIMER_CONTROL})
            decode = SEL_CONTROL;
        else if (idx == {2'h0, IDX_PERIPH_ENABLES})
            decode = SEL_ENABLES;
        else if (idx == {2'h0, IDX_TIMER_PERIOD})
            decode = SEL_PERIOD;
        else
            decode = SEL_NONE;
    endfunction

    // write channel: address and data taken in either order, one write at a time
    assign wr_fire     = !o_awready && !o_wready && !o_bvalid;
    assign wr_sel      = decode(aw_addr_reg);
    assign wr_count    = wr_fire && w_lane_reg && (wr_sel == SEL_COUNT);
    assign wr_control  = wr_fire && w_lane_reg && (wr_sel == SEL_CONTROL);
    assign wr_period   = wr_fire && w_lane_reg && (wr_sel == SEL_PERIOD);
    assign wr_flags    = wr_fire && w_lane_reg && (wr_sel == SEL_FLAGS);
    assign wr_enables  = wr_fire && w_lane_reg && (wr_sel == SEL_ENABLES);
    assign wr_core_irq = wr_fire && w_lane_reg && (wr_sel == SEL_CORE_IRQ);

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_awready   <= 1'b1;
            aw_addr_reg <= '0;
        end
        else if (o_awready && i_awvalid)
        begin
            o_awready   <= 1'b0;
            aw_addr_reg <= i_awaddr;
        end
        else if (o_bvalid && i_bready)
            o_awready <= 1'b1;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_wready   <= 1'b1;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end
        else if (o_wready && i_wvalid)
        begin
            o_wready   <= 1'b0;
            w_data_reg <= i_wdata[7:0];
            w_lane_reg <= i_wstrb[0];
        end
        else if (o_bvalid && i_bready)
            o_wready <= 1'b1;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_bvalid <= 1'b0;
            o_bresp  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            o_bvalid <= 1'b1;
            o_bresp  <= (wr_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
        end
        else if (o_bvalid && i_bready)
            o_bvalid <= 1'b0;
    end

    // read side; unused and unimplemented bits are zero
    assign rd_sel = decode(i_araddr);

    always_comb
    begin
        rd_value = 8'h00;
        case (rd_sel)
            SEL_CORE_IRQ:
            begin
                rd_value[GLOBAL_IRQ_EN_BIT] = global_ie_reg;
                rd_value[PERIPH_IRQ_EN_BIT] = periph_ie_reg;
            end
            SEL_FLAGS:   rd_value[MATCH_FLAG_BIT] = match_flag_reg;
            SEL_ENABLES: rd_value[MATCH_IE_BIT] = match_ie_reg;
            SEL_COUNT:   rd_value = count_reg;
            SEL_CONTROL: rd_value = {1'b0, ctrl_reg};
            SEL_PERIOD:  rd_value = period_reg;
            default:     rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= '0;
            o_rresp   <= RESP_OKAY;
        end
        else if (o_arready && i_arvalid)
        begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= {24'h000000, rd_value};
            o_rresp   <= (rd_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
        end
        else if (o_rvalid && i_rready)
        begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    // timing chain
    assign count_clear = wr_count || wr_control;

    pmt_prescaler u_prescaler (
        .i_core_clk        (i_core_clk),
        .i_rst_b           (i_rst_b),
        .i_clear           (count_clear),
        .i_prescale_select (ctrl_reg.prescale_select),
        .o_tick            (tick)
    );

    // a control write restarts the prescale phase, so no step that cycle
    assign match_event = tick && ctrl_reg.timer_run_enable && !count_clear
                         && (count_reg == period_reg);
    assign post_expire = match_event && (post_cnt_reg == ctrl_reg.postscale_select);

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            count_reg <= COUNT_RST;
        else if (wr_count)
            count_reg <= w_data_reg;
        else if (wr_control)
            count_reg <= count_reg;
        else if (match_event)
            count_reg <= 8'h00;
        else if (tick && ctrl_reg.timer_run_enable)
            count_reg <= count_reg + 8'h01;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            period_reg <= PERIOD_RST;
        else if (wr_period)
            period_reg <= w_data_reg;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            ctrl_reg <= CTRL_RST;
        else if (wr_control)
            ctrl_reg <= w_data_reg[CTRL_W-1:0];
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            post_cnt_reg <= POST_RST;
        else if (count_clear)
            post_cnt_reg <= POST_RST;
        else if (post_expire)
            post_cnt_reg <= POST_RST;
        else if (match_event)
            post_cnt_reg <= post_cnt_reg + 4'h1;
    end

    // hardware set beats a software clear in the same cycle
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            match_flag_reg <= 1'b0;
        else if (post_expire)
            match_flag_reg <= 1'b1;
        else if (wr_flags)
            match_flag_reg <= w_data_reg[MATCH_FLAG_BIT];
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            match_ie_reg <= 1'b0;
        else if (wr_enables)
            match_ie_reg <= w_data_reg[MATCH_IE_BIT];
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            global_ie_reg <= 1'b0;
            periph_ie_reg <= 1'b0;
        end
        else if (wr_core_irq)
        begin
            global_ie_reg <= w_data_reg[GLOBAL_IRQ_EN_BIT];
            periph_ie_reg <= w_data_reg[PERIPH_IRQ_EN_BIT];
        end
    end

    // outputs registered; one cycle behind the internal state
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_serial_match <= 1'b0;
            o_pwm_feed     <= '0;
            o_irq          <= 1'b0;
        end
        else
        begin
            o_serial_match          <= match_event;
            o_pwm_feed.value        <= count_reg;
            o_pwm_feed.period_match <= match_event;
            o_irq <= match_flag_reg && match_ie_reg && periph_ie_reg && global_ie_reg;
        end
    end

    a_count_wraps: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        tick && ctrl_reg.timer_run_enable && !count_clear && count_reg == period_reg
        |=> count_reg == 8'h00 && o_serial_match)
        else $error("count did not wrap at period");

    a_count_steps: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        tick && ctrl_reg.timer_run_enable && !count_clear && count_reg != period_reg
        |=> count_reg == $past(count_reg) + 8'h01)
        else $error("count did not step by one");

    a_halt_holds: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !ctrl_reg.timer_run_enable && !wr_count |=> count_reg == $past(count_reg))
        else $error("count moved while halted");

    a_control_keeps: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        wr_control |=> count_reg == $past(count_reg) && post_cnt_reg == POST_RST)
        else $error("control write disturbed count");

    a_count_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        wr_count |=> count_reg == $past(w_data_reg) && post_cnt_reg == POST_RST)
        else $error("count write not applied");

    a_flag_expiry: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        match_event && post_cnt_reg == ctrl_reg.postscale_select |=> match_flag_reg)
        else $error("flag not set on postscale expiry");

    a_flag_early: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !match_flag_reg && !wr_flags ##1 match_flag_reg |-> $past(post_expire))
        else $error("flag set without postscale expiry");

    a_irq_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        o_irq |-> $past(match_flag_reg && match_ie_reg && periph_ie_reg && global_ie_reg))
        else $error("irq without all enables");

    a_period_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        wr_period |=> period_reg == $past(w_data_reg))
        else $error("period write not applied");

    a_pwm_feed: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        ##1 o_pwm_feed.value == $past(count_reg) && o_pwm_feed.period_match == o_serial_match)
        else $error("pwm feed out of step");

    a_upper_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        o_rvalid |-> o_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    a_read_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped before taken");

    c_wrap: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) match_event);
    c_flag: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) post_expire && wr_flags);
    c_irq: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) o_irq);
    c_bad_read: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
        o_rvalid && o_rresp == RESP_DECERR);

endmodule

// *** hdl/pmt_pkg.sv ***
package pmt_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_CORE_IRQ_CTRL  = 8'h0B;
    localparam logic [7:0] IDX_PERIPH_FLAGS   = 8'h0C;
    localparam logic [7:0] IDX_TIMER_COUNT    = 8'h11;
    localparam logic [7:0] IDX_TIMER_CONTROL  = 8'h12;
    localparam logic [7:0] IDX_PERIPH_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_TIMER_PERIOD   = 8'h92;

    // field positions
    localparam int GLOBAL_IRQ_EN_BIT = 7;
    localparam int PERIPH_IRQ_EN_BIT = 6;
    localparam int MATCH_FLAG_BIT    = 1;
    localparam int MATCH_IE_BIT      = 1;
    localparam int CTRL_W            = 7;

    // values after reset
    localparam logic [7:0]        COUNT_RST  = 8'h00;
    localparam logic [7:0]        PERIOD_RST = 8'hFF;
    localparam logic [CTRL_W-1:0] CTRL_RST   = 7'h00;
    localparam logic [3:0]        POST_RST   = 4'h0;

    // instruction clock is the core clock divided by four
    localparam logic [1:0] INSTR_DIV_TC = 2'h3;
    // prescaler terminal counts for 1:1, 1:4, 1:16
    localparam logic [3:0] PRE_TC_1  = 4'h0;
    localparam logic [3:0] PRE_TC_4  = 4'h3;
    localparam logic [3:0] PRE_TC_16 = 4'hF;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_CORE_IRQ,
        SEL_FLAGS,
        SEL_COUNT,
        SEL_CONTROL,
        SEL_ENABLES,
        SEL_PERIOD
    } pmt_reg_sel_t;

    typedef struct packed {
        logic [3:0] postscale_select;
        logic       timer_run_enable;
        logic [1:0] prescale_select;
    } pmt_ctrl_t;

    typedef struct packed {
        logic [7:0] value;
        logic       period_match;
    } pmt_pwm_feed_t;

endpackage

// *** hdl/pmt_prescaler.sv ***
module pmt_prescaler
    import pmt_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_clear,
    input  wire logic [1:0] i_prescale_select,
    output logic            o_tick
);

    logic [1:0] quarter_reg;
    logic [3:0] pre_cnt_reg;
    logic       instr_en;
    logic [3:0] pre_tc;

    function automatic logic [3:0] pre_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    pre_limit = PRE_TC_1;
            2'h1:    pre_limit = PRE_TC_4;
            default: pre_limit = PRE_TC_16;
        endcase
    endfunction

    assign instr_en = (quarter_reg == INSTR_DIV_TC);
    assign pre_tc   = pre_limit(i_prescale_select);

    // free running; only the prescale count is cleared
    always_ff @(posedge i_core_clk or negedge i_rst_b)
        if (!i_rst_b)
            quarter_reg <= 2'h0;
        else
            quarter_reg <= quarter_reg + 2'h1;

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            pre_cnt_reg <= 4'h0;
        else if (i_clear)
            pre_cnt_reg <= 4'h0;
        else if (instr_en)
            pre_cnt_reg <= (pre_cnt_reg >= pre_tc) ? 4'h0 : pre_cnt_reg + 4'h1;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
        if (!i_rst_b)
            o_tick <= 1'b0;
        else
            o_tick <= instr_en && (pre_cnt_reg >= pre_tc) && !i_clear;

    a_prescale_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_clear |=> pre_cnt_reg == 4'h0 && !o_tick)
        else $error("prescaler not cleared");

    a_tick_spacing: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        o_tick |=> !o_tick [*3])
        else $error("ticks closer than one instruction cycle");

endmodule

// *** verif/tb_period_match_timer.sv ***
module tb_period_match_timer
    import pmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                clk;
    logic                rst_b;
    logic                awvalid;
    logic                wvalid;
    logic                bready;
    logic                arvalid;
    logic                rready;
    logic [ADDR_W-1:0]   awaddr;
    logic [ADDR_W-1:0]   araddr;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   rdata;
    logic [3:0]          wstrb;
    logic [2:0]          awprot;
    logic [2:0]          arprot;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic                arready;
    logic                rvalid;
    logic [1:0]          bresp;
    logic [1:0]          rresp;
    logic                ser;
    logic                irq;
    pmt_pwm_feed_t       pwm;
    int                  fails;
    int                  samples_checked;
    int                  cyc;
    int                  pulses;
    int                  mdl [6];
    logic [7:0]          idx_a [6] = '{IDX_CORE_IRQ_CTRL, IDX_PERIPH_FLAGS, IDX_TIMER_COUNT,
                                       IDX_TIMER_CONTROL, IDX_PERIPH_ENABLES, IDX_TIMER_PERIOD};
    // only these bits are stored; the rest must read back as zero
    logic [7:0]          msk_a [6] = '{8'hC0, 8'h02, 8'hFF, 8'h7F, 8'h02, 8'hFF};

    pmt_timer pmt_timer_i (
        .i_core_clk     (clk),
        .i_rst_b        (rst_b),
        .i_awvalid      (awvalid),
        .o_awready      (awready),
        .i_awaddr       (awaddr),
        .i_awprot       (awprot),
        .i_wvalid       (wvalid),
        .o_wready       (wready),
        .i_wdata        (wdata),
        .i_wstrb        (wstrb),
        .o_bvalid       (bvalid),
        .i_bready       (bready),
        .o_bresp        (bresp),
        .i_arvalid      (arvalid),
        .o_arready      (arready),
        .i_araddr       (araddr),
        .i_arprot       (arprot),
        .o_rvalid       (rvalid),
        .i_rready       (rready),
        .o_rdata        (rdata),
        .o_rresp        (rresp),
        .o_serial_match (ser),
        .o_pwm_feed     (pwm),
        .o_irq          (irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // base/difference counting avoids racing the main sequence on this counter
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (ser === 1'b1) pulses <= pulses + 1;
        if (cyc == 20000)
        begin
            fails++;
            conclude();
        end
    end

    task automatic conclude;
        if (fails == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [1:0] er;
        er = RESP_DECERR;
        foreach (idx_a[j])
            if (idx_a[j] == idx)
            begin
                mdl[j] = d & msk_a[j];
                er = RESP_OKAY;
            end
        @(posedge clk);
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                bready <= 1'b0;
                check(bresp, er);
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd_chk(input int k);
        logic [31:0] d;
        logic [1:0]  r;
        rd(idx_a[k], d, r);
        check(d, mdl[k]);
        check(r, RESP_OKAY);
    endtask

    task automatic wait_ser(output int t);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ser !== 1'b1 && n < 3000);
        check(ser, 1'b1);
        t = cyc;
    endtask

    initial
    begin
        int          t0;
        int          t1;
        int          p;
        int          base;
        int          n;
        int          nl [4];
        logic [3:0]  q;
        logic [31:0] d;
        logic [1:0]  r;
        fails = 0;
        samples_checked = 0;
        cyc = 0;
        pulses = 0;
        rst_b = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        awprot = 3'h0;
        arprot = 3'h0;
        foreach (mdl[j]) mdl[j] = 0;
        mdl[5] = 8'hFF;
        void'($urandom(42479));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        for (int k = 0; k < 6; k++) rd_chk(k);
        rd(8'h13, d, r);
        check(r, RESP_DECERR);
        wr(8'h13, 8'($urandom));
        // run bit kept low so the count stays put for readback
        for (int k = 0; k < 6; k++) wr(idx_a[k], (k == 3) ? 8'($urandom) & 8'hFB : 8'($urandom));
        for (int k = 0; k < 6; k++) rd_chk(k);
        // low byte lane off: the write is answered but must not land
        d = mdl[5];
        wstrb <= 4'hE;
        wr(IDX_TIMER_PERIOD, ~d[7:0]);
        wstrb <= 4'hF;
        mdl[5] = d;
        rd_chk(5);
        wr(IDX_TIMER_CONTROL, 8'h00);
        wr(IDX_TIMER_COUNT, 8'h20);
        wr(IDX_TIMER_CONTROL, 8'h7B);
        rd_chk(2);
        check(pwm.value, 8'h20);
        repeat (40) @(posedge clk);
        rd_chk(2);
        for (int ps = 0; ps < 4; ps++)
        begin
            p = $urandom_range(0, 3);
            wr(IDX_TIMER_CONTROL, 8'h00);
            wr(IDX_TIMER_COUNT, 8'h00);
            wr(IDX_TIMER_PERIOD, 8'(p));
            wr(IDX_TIMER_CONTROL, 8'h04 | 8'(ps));
            wait_ser(t0);
            wait_ser(t1);
            check(t1 - t0, (p + 1) * 4 * (ps == 0 ? 1 : ps == 1 ? 4 : 16));
            check(pwm.period_match, 1'b1);
        end
        wr(IDX_PERIPH_ENABLES, 8'h02);
        wr(IDX_CORE_IRQ_CTRL, 8'hC0);
        wr(IDX_TIMER_PERIOD, 8'h00);
        nl = '{0, 3, 15, 0};
        nl[3] = $urandom_range(1, 14);
        foreach (nl[i])
        begin
            q = 4'(nl[i]);
            // one match first, so a postscaler that is not cleared gets caught
            wr(IDX_TIMER_CONTROL, {1'b0, q, 1'b1, 2'b01});
            wait_ser(t0);
            wr(IDX_TIMER_CONTROL, {1'b0, q, 1'b0, 2'b01});
            wr(IDX_PERIPH_FLAGS, 8'h00);
            wr(IDX_TIMER_COUNT, 8'h00);
            base = pulses;
            wr(IDX_TIMER_CONTROL, {1'b0, q, 1'b1, 2'b01});
            n = 0;
            while (irq !== 1'b1 && n < 2000)
            begin
                @(posedge clk);
                n++;
            end
            check(irq, 1'b1);
            repeat (2) @(posedge clk);
            check(pulses - base, nl[i] + 1);
            wr(IDX_TIMER_CONTROL, {1'b0, q, 1'b0, 2'b01});
            rd(IDX_PERIPH_FLAGS, d, r);
            check(d, 32'h2);
        end
        wr(IDX_CORE_IRQ_CTRL, 8'h40);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        wr(IDX_CORE_IRQ_CTRL, 8'hC0);
        repeat (2) @(posedge clk);
        check(irq, 1'b1);
        wr(IDX_PERIPH_ENABLES, 8'h00);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        wr(IDX_PERIPH_ENABLES, 8'h02);
        wr(IDX_PERIPH_FLAGS, 8'h00);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        wr(IDX_TIMER_PERIOD, 8'h40);
        wr(IDX_TIMER_CONTROL, 8'h04);
        repeat (30) @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        foreach (mdl[j]) mdl[j] = 0;
        mdl[5] = 8'hFF;
        for (int k = 0; k < 6; k++) rd_chk(k);
        conclude();
    end
endmodule
